// ==== amc_mode_ctrl.sv ====
/*
 * Operating mode sequencer of a sigma-delta converter: continuous, single,
 * idle, power-down and internal zero-scale calibration, ready pin, result
 * holding and readout, and an AXI4-Lite register file with an interrupt.
 * Assumes the modulator/filter supplies a result word with a strobe, and a
 * serial front end that is offered the held result with o_result_valid.
 */
`include "amc_params.svh"

module amc_mode_ctrl #(
   parameter int unsigned CHANNELS = 6,
   parameter int unsigned SETTLE_CYCLES = `AMC_OSC_SETTLE_CYC
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset,
   // AXI4-Lite write channels.
   input wire logic [11:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read channels.
   input wire logic [11:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Converter core.
   input wire logic [23:0] i_conv_data,
   input wire logic i_conv_strobe,
   output logic o_modulator_reset,
   output logic o_power_down,
   output logic o_input_short,
   output logic o_clock_output_pin_en,
   output logic [2:0] o_cal_channel,
   // Serial front end.
   output logic [23:0] o_result,
   output logic o_result_valid,
   input wire logic i_result_taken,
   output logic o_ready_n,
   // Interrupt.
   output logic o_irq
);
   initial begin
      if (CHANNELS < 1 || CHANNELS > 8) $error("amc_mode_ctrl: CHANNELS out of range");
      if (SETTLE_CYCLES < 1) $error("amc_mode_ctrl: SETTLE_CYCLES too small");
   end

   typedef struct packed {
      amc_pkg::amc_state_t st;
      logic [31:0] mode_reg;
      logic [31:0] rate;
      logic [1:0] irq_st;
      logic [1:0] irq_mask;
      logic [23:0] data;
      logic ready_n;
      logic out_valid;
      logic first;
      logic [1:0] per_cnt;
      logic aw_hold;
      logic [11:0] awaddr;
      logic w_hold;
      logic [31:0] wdata;
      logic bvalid;
      logic bad_w;
      logic rvalid;
      logic [31:0] rdata;
      logic bad_r;
      logic [CHANNELS-1:0][23:0] offset;
      logic restart;
   } amc_core_t;

   amc_core_t s_q;
   amc_core_t s_d;

   amc_tick_if tick_if ();
   logic settle_start;
   logic settle_done;

   amc_rate_timer #(
      .WIDTH(32)
   ) u_rate (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .tif(tick_if.timer)
   );

   amc_settle_timer #(
      .CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_start(settle_start),
      .i_run(s_q.st == amc_pkg::AMC_ST_SETTLE),
      .o_done(settle_done)
   );

   amc_pkg::amc_mode_t mode;
   logic chop_disable_bit;
   logic [2:0] chan;
   logic [1:0] need;
   logic aw_ok;
   logic w_ok;
   logic wr_go;
   logic rd_go;
   logic mode_wr;
   logic result_read;

   assign mode = amc_pkg::amc_mode_t'(s_q.mode_reg[`AMC_MODE_LSB +: 3]);
   assign chop_disable_bit = s_q.mode_reg[`AMC_CHOP_DISABLE_BIT_BIT];
   assign chan = s_q.mode_reg[`AMC_CHAN_LSB +: 3];
   // Two output periods to the first result or a calibration with chop, one without.
   assign need = chop_disable_bit ? 2'h1 : 2'h2;

   assign o_awready = !s_q.aw_hold && !s_q.bvalid;
   assign o_wready = !s_q.w_hold && !s_q.bvalid;
   assign aw_ok = s_q.aw_hold || (i_awvalid && o_awready);
   assign w_ok = s_q.w_hold || (i_wvalid && o_wready);
   assign wr_go = aw_ok && w_ok && !s_q.bvalid;
   assign o_arready = !s_q.rvalid;
   assign rd_go = i_arvalid && o_arready;

   // Read of the result over the bus or a taken serial word both count.
   assign result_read = i_result_taken || (rd_go && i_araddr == `AMC_OFF_DATA);

   // A mode write drops run for one cycle so the output period starts afresh.
   assign tick_if.run = ((s_q.st == amc_pkg::AMC_ST_CONV) || (s_q.st == amc_pkg::AMC_ST_CAL))
      && !s_q.restart;
   assign tick_if.period = s_q.rate;
   // Only a fresh mode write starts a single conversion; a read must not restart it.
   assign settle_start = (s_q.st == amc_pkg::AMC_ST_PDOWN) && mode == amc_pkg::AMC_MODE_SINGLE
      && s_q.first;

   always_comb begin
      logic [11:0] wa;
      logic [31:0] wd;
      logic [31:0] nm;
      logic done_ev;
      logic cal_ev;
      s_d = s_q;
      wa = s_q.aw_hold ? s_q.awaddr : i_awaddr;
      wd = s_q.w_hold ? s_q.wdata : i_wdata;
      nm = s_q.mode_reg;
      done_ev = 1'b0;
      cal_ev = 1'b0;
      mode_wr = 1'b0;
      s_d.restart = 1'b0;
      if (i_awvalid && o_awready && !wr_go) begin
         s_d.aw_hold = 1'b1;
         s_d.awaddr = i_awaddr;
      end
      if (i_wvalid && o_wready && !wr_go) begin
         s_d.w_hold = 1'b1;
         s_d.wdata = i_wdata;
      end
      if (i_bready && s_q.bvalid) s_d.bvalid = 1'b0;
      if (i_rready && s_q.rvalid) s_d.rvalid = 1'b0;

      // Sequencer; a mode write below overrides the state, mode and period count set here.
      unique case (s_q.st)
         amc_pkg::AMC_ST_IDLE: begin
            s_d.per_cnt = 2'h0;
         end
         amc_pkg::AMC_ST_PDOWN: begin
            if (settle_start) s_d.st = amc_pkg::AMC_ST_SETTLE;
         end
         amc_pkg::AMC_ST_SETTLE: begin
            if (settle_done) begin
               s_d.st = amc_pkg::AMC_ST_CONV;
               s_d.per_cnt = 2'h0;
            end
         end
         amc_pkg::AMC_ST_CONV: begin
            if (tick_if.tick) begin
               s_d.per_cnt = s_q.per_cnt + 2'h1;
               // After the first result each period yields one result.
               if (!s_q.first || s_q.per_cnt + 2'h1 == need) begin
                  s_d.first = 1'b0;
                  s_d.per_cnt = 2'h0;
                  done_ev = 1'b1;
                  s_d.data = i_conv_strobe ? i_conv_data : s_q.data;
                  s_d.ready_n = 1'b0;
                  s_d.out_valid = s_q.mode_reg[`AMC_CONT_READ_BIT];
                  if (mode == amc_pkg::AMC_MODE_SINGLE) begin
                     s_d.st = amc_pkg::AMC_ST_PDOWN;
                  end
               end
            end
         end
         amc_pkg::AMC_ST_CAL: begin
            if (tick_if.tick) begin
               s_d.per_cnt = s_q.per_cnt + 2'h1;
               if (s_q.per_cnt + 2'h1 == need) begin
                  cal_ev = 1'b1;
                  s_d.ready_n = 1'b0;
                  s_d.offset[chan] = i_conv_data;
                  s_d.st = amc_pkg::AMC_ST_IDLE;
                  nm[`AMC_MODE_LSB +: 3] = amc_pkg::AMC_MODE_IDLE;
                  s_d.mode_reg = nm;
               end
            end
         end
         default: s_d.st = amc_pkg::AMC_ST_IDLE;
      endcase

      if (result_read) begin
         s_d.ready_n = 1'b1;
         s_d.out_valid = 1'b0;
      end
      if (done_ev) begin
         s_d.ready_n = 1'b0;
         s_d.out_valid = s_q.mode_reg[`AMC_CONT_READ_BIT];
      end

      if (wr_go) begin
         s_d.aw_hold = 1'b0;
         s_d.w_hold = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bad_w = 1'b0;
         case (wa)
            `AMC_OFF_MODE: begin
               mode_wr = 1'b1;
               s_d.mode_reg = wd & 32'h0000_073F;
            end
            `AMC_OFF_IRQ_MASK: s_d.irq_mask = wd[1:0];
            `AMC_OFF_READ_REQ: begin
               if (wd[0]) s_d.out_valid = 1'b1;
            end
            `AMC_OFF_RATE: begin
               if (wd > 32'h0000_0001) s_d.rate = wd;
            end
            default: s_d.bad_w = 1'b1;
         endcase
      end

      // A mode write restarts the sequencer and drops any conversion.
      if (mode_wr) begin
         s_d.restart = 1'b1;
         s_d.per_cnt = 2'h0;
         s_d.first = 1'b1;
         unique case (amc_pkg::amc_mode_t'(s_d.mode_reg[`AMC_MODE_LSB +: 3]))
            amc_pkg::AMC_MODE_CONT: s_d.st = amc_pkg::AMC_ST_CONV;
            amc_pkg::AMC_MODE_SINGLE: begin
               s_d.st = amc_pkg::AMC_ST_PDOWN;
               s_d.ready_n = 1'b1;
            end
            amc_pkg::AMC_MODE_PDOWN: s_d.st = amc_pkg::AMC_ST_PDOWN;
            amc_pkg::AMC_MODE_ZCAL: begin
               s_d.st = amc_pkg::AMC_ST_CAL;
               s_d.ready_n = 1'b1;
            end
            default: s_d.st = amc_pkg::AMC_ST_IDLE;
         endcase
      end

      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.bad_r = 1'b0;
         case (i_araddr)
            `AMC_OFF_MODE: s_d.rdata = s_q.mode_reg;
            `AMC_OFF_STATUS: begin
               s_d.rdata = 32'h0000_0000;
               s_d.rdata[`AMC_ST_DONE +: 2] = s_q.irq_st;
               s_d.rdata[`AMC_ST_RDY_N] = s_q.ready_n;
               s_d.rdata[`AMC_ST_MODE_LSB +: 3] = s_q.st;
               s_d.irq_st = 2'h0;
            end
            `AMC_OFF_IRQ_MASK: s_d.rdata = {30'h0000_0000, s_q.irq_mask};
            `AMC_OFF_DATA: s_d.rdata = {8'h00, s_q.data};
            `AMC_OFF_RATE: s_d.rdata = s_q.rate;
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.bad_r = 1'b1;
               if (i_araddr >= `AMC_OFF_OFFSET0 && i_araddr[1:0] == 2'h0
                     && 32'(i_araddr - `AMC_OFF_OFFSET0) < 32'(CHANNELS * 4)) begin
                  s_d.rdata = {8'h00, s_q.offset[3'((i_araddr - `AMC_OFF_OFFSET0) >> 2)]};
                  s_d.bad_r = 1'b0;
               end
            end
         endcase
      end
      // Events win over a clearing read in the same cycle.
      if (done_ev) s_d.irq_st[`AMC_ST_DONE] = 1'b1;
      if (cal_ev) s_d.irq_st[`AMC_ST_CAL_DONE] = 1'b1;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         s_q <= '0;
         s_q.st <= amc_pkg::AMC_ST_CONV;
         s_q.mode_reg <= `AMC_MODE_RESET;
         s_q.rate <= `AMC_RATE_RESET;
         s_q.ready_n <= 1'b1;
         s_q.first <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_bvalid = s_q.bvalid;
   assign o_bresp = s_q.bad_w ? 2'h2 : 2'h0;
   assign o_rvalid = s_q.rvalid;
   assign o_rdata = s_q.rdata;
   assign o_rresp = s_q.bad_r ? 2'h2 : 2'h0;

   // Filter and modulator stay in reset outside conversions.
   assign o_modulator_reset = !((s_q.st == amc_pkg::AMC_ST_CONV)
      || (s_q.st == amc_pkg::AMC_ST_CAL));
   assign o_power_down = (s_q.st == amc_pkg::AMC_ST_PDOWN);
   assign o_clock_output_pin_en = !o_power_down;
   assign o_input_short = (s_q.st == amc_pkg::AMC_ST_CAL);
   assign o_cal_channel = chan;
   assign o_result = s_q.data;
   // With continuous read each new result is offered without a command.
   assign o_result_valid = s_q.out_valid;
   assign o_ready_n = s_q.ready_n;
   assign o_irq = |(s_q.irq_st & s_q.irq_mask);
endmodule : amc_mode_ctrl

// ==== amc_params.svh ====
/*
 * Constants of the ADC operating mode sequencer: register offsets, field
 * positions, reset values and timing figures.
 * Assumes a 40 MHz core clock and an AXI4-Lite register bus with 32-bit data.
 */
`ifndef AMC_PARAMS_SVH
`define AMC_PARAMS_SVH

// Register byte offsets.
`define AMC_OFF_MODE 12'h000
`define AMC_OFF_STATUS 12'h004
`define AMC_OFF_IRQ_MASK 12'h008
`define AMC_OFF_DATA 12'h00C
`define AMC_OFF_READ_REQ 12'h010
`define AMC_OFF_RATE 12'h014
`define AMC_OFF_OFFSET0 12'h020

// Mode register fields.
`define AMC_MODE_LSB 0
`define AMC_CHOP_DISABLE_BIT_BIT 4
`define AMC_CONT_READ_BIT 5
`define AMC_CHAN_LSB 8
`define AMC_MODE_RESET 32'h0000_0000

// Status and interrupt bits.
`define AMC_ST_DONE 0
`define AMC_ST_CAL_DONE 1
`define AMC_ST_RDY_N 8
`define AMC_ST_MODE_LSB 12

// Timing figures.
`define AMC_CLK_MHZ 40
`define AMC_OSC_SETTLE_US 1000
`define AMC_OSC_SETTLE_CYC (`AMC_OSC_SETTLE_US * `AMC_CLK_MHZ)
`define AMC_RATE_RESET 32'h0000_0100

`endif

// ==== amc_pkg.sv ====
/*
 * Types of the ADC operating mode sequencer.
 * Assumes amc_params.svh for the numeric constants.
 */
package amc_pkg;
   typedef enum logic [2:0] {
      AMC_MODE_CONT = 3'h0,
      AMC_MODE_SINGLE = 3'h1,
      AMC_MODE_IDLE = 3'h2,
      AMC_MODE_PDOWN = 3'h3,
      AMC_MODE_ZCAL = 3'h4,
      AMC_MODE_FCAL = 3'h5,
      AMC_MODE_SZCAL = 3'h6,
      AMC_MODE_SFCAL = 3'h7
   } amc_mode_t;

   typedef enum logic [2:0] {
      AMC_ST_IDLE = 3'h0,
      AMC_ST_PDOWN = 3'h1,
      AMC_ST_SETTLE = 3'h2,
      AMC_ST_CONV = 3'h3,
      AMC_ST_CAL = 3'h4
   } amc_state_t;
endpackage : amc_pkg

// ==== amc_tick_if.sv ====
/*
 * Carrier between the sequencer and its output-rate timer.
 * Assumes one clock domain shared by both ends.
 */
interface amc_tick_if;
   logic run;
   logic [31:0] period;
   logic tick;
   modport timer (input run, input period, output tick);
   modport user (output run, output period, input tick);
endinterface : amc_tick_if

// ==== amc_rate_timer.sv ====
/*
 * Output-rate timer: one tick each period while run is high, restarted
 * whenever run falls. Assumes a period of at least two cycles.
 */
module amc_rate_timer #(
   parameter int unsigned WIDTH = 32
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Timer carrier.
   amc_tick_if.timer tif
);
   initial begin
      if (WIDTH < 2 || WIDTH > 32) $error("amc_rate_timer: WIDTH out of range");
   end

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } amc_tmr_t;

   amc_tmr_t s_q;
   amc_tmr_t s_d;

   always_comb begin
      s_d = s_q;
      if (!tif.run || tif.tick) begin
         s_d.cnt = '0;
      end else begin
         s_d.cnt = s_q.cnt + WIDTH'(1);
      end
   end

   assign tif.tick = tif.run && (s_q.cnt == tif.period[WIDTH-1:0] - WIDTH'(1));

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : amc_rate_timer

// ==== amc_settle_timer.sv ====
/*
 * Oscillator settle timer: starts on a pulse and raises done for one cycle
 * after the set number of cycles. A low run aborts it.
 */
`include "amc_params.svh"

module amc_settle_timer #(
   parameter int unsigned CYCLES = `AMC_OSC_SETTLE_CYC
) (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Control.
   input wire logic i_start,
   input wire logic i_run,
   output logic o_done
);
   initial begin
      if (CYCLES < 1) $error("amc_settle_timer: CYCLES must be at least one");
   end

   typedef struct packed {
      logic busy;
      logic [31:0] cnt;
   } amc_set_t;

   amc_set_t s_q;
   amc_set_t s_d;

   always_comb begin
      s_d = s_q;
      // The start pulse comes before run rises, so it must win over a low run.
      if (i_start) begin
         s_d.busy = 1'b1;
         s_d.cnt = 32'h0000_0000;
      end else if (!i_run) begin
         s_d.busy = 1'b0;
      end else if (s_q.busy) begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
         if (o_done) s_d.busy = 1'b0;
      end
   end

   assign o_done = s_q.busy && (s_q.cnt == 32'(CYCLES - 1));

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : amc_settle_timer

// ==== amc_mode_ctrl_chk.sv ====
/* Port assertions for the mode sequencer.
   Assumes one clock domain with a synchronous active-high reset. */
module amc_mode_ctrl_chk (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Bus handshakes.
   input wire logic o_awready,
   input wire logic o_bvalid,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   // Converter side.
   input wire logic o_modulator_reset,
   input wire logic o_power_down,
   input wire logic o_clock_output_pin_en,
   input wire logic o_input_short,
   input wire logic o_ready_n,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   reset_default_a: assert property (disable iff (1'b0) i_reset |=>
      o_ready_n && !o_bvalid && !o_rvalid && !o_irq) else $error("reset state wrong");
   clk_out_a: assert property (o_clock_output_pin_en == !o_power_down)
      else $error("clock output enable wrong");
   pdown_mod_a: assert property (o_power_down |-> o_modulator_reset)
      else $error("modulator live in power-down");
   short_live_a: assert property (o_input_short |-> !o_modulator_reset && !o_power_down)
      else $error("short outside calibration");
   cal_ready_a: assert property (o_input_short |-> o_ready_n)
      else $error("ready low during calibration");
   cal_end_a: assert property ($fell(o_input_short) |-> ##[0:2] !o_ready_n)
      else $error("ready not low after calibration");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   write_refuse_a: assert property (o_bvalid |-> !o_awready)
      else $error("address taken during response");
endmodule : amc_mode_ctrl_chk

bind amc_mode_ctrl amc_mode_ctrl_chk i_chk (.*);

// ==== amc_host_model.sv ====
/* Host on the result port: takes each offered result, at once or after a stall.
   Assumes the offer stands until the one-cycle take pulse is seen. */
module amc_host_model (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Result port.
   input wire logic i_valid,
   input wire logic [23:0] i_result,
   input wire logic i_slow,
   output logic o_taken,
   output logic [23:0] o_captured,
   output int o_count
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_q;
   initial o_taken = 1'b0;
   always @(posedge i_core_clk) begin
      o_taken <= 1'b0;
      if (i_reset) begin
         wait_q <= 0;
         o_count <= 0;
      end else if (i_valid && !o_taken) begin
         // A slow host stalls so the offer must be seen to stand.
         if (wait_q >= (i_slow ? 5 : 0)) begin
            o_taken <= 1'b1;
            o_captured <= i_result;
            o_count <= o_count + 1;
            wait_q <= 0;
         end else begin
            wait_q <= wait_q + 1;
         end
      end
   end
endmodule : amc_host_model

// ==== amc_mode_ctrl_test.sv ====
/* Self-checking bench of the mode sequencer with a host on the result port.
   Assumes amc_params.svh, amc_pkg and the host model are compiled first. */
`include "amc_params.svh"
module amc_mode_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = 8;
   localparam int SETTLE = 20;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [11:0] i_awaddr = 12'h000;
   logic [11:0] i_araddr = 12'h000;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic [3:0] i_wstrb = 4'hF;
   logic i_awvalid = 1'b0;
   logic i_wvalid = 1'b0;
   logic i_bready = 1'b0;
   logic i_arvalid = 1'b0;
   logic i_rready = 1'b0;
   logic [23:0] i_conv_data = 24'h000001;
   logic i_conv_strobe = 1'b1;
   logic i_result_taken, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic o_modulator_reset, o_power_down, o_input_short, o_clock_output_pin_en;
   logic o_result_valid, o_ready_n, o_irq, slow;
   logic [1:0] o_bresp, o_rresp, sr;
   logic [31:0] o_rdata, sd;
   logic [2:0] o_cal_channel;
   logic [23:0] o_result, conv_s, got;
   logic [23:0] last_res = 24'h000000;
   int cyc = 0, t_res = 0, res_cnt = 0, pc, errors = 0, checks = 0;
   amc_mode_ctrl #(.SETTLE_CYCLES(SETTLE)) i_dut (.*);
   amc_host_model i_host (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_valid(o_result_valid),
      .i_result(o_result), .i_slow(slow), .o_taken(i_result_taken), .o_captured(got),
      .o_count(pc));
   initial forever #12.5 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      conv_s <= i_conv_data;
      i_conv_data <= {i_conv_data[22:0],
         i_conv_data[23] ^ i_conv_data[22] ^ i_conv_data[21] ^ i_conv_data[16]};
   end
   always @(negedge i_core_clk) begin
      if (!i_reset && o_result !== last_res) begin
         last_res = o_result;
         t_res = cyc;
         res_cnt++;
         chk("result", o_result, conv_s);
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic guard(inout int n);
      n++;
      if (n > 3000) begin
         errors++;
         $display("ERROR wait expected done seen timeout");
         results();
      end
   endtask : guard
   // Write-path latency is left open, so timing is judged within two cycles.
   function automatic logic near(input int a, input int b);
      return a >= b - 2 && a <= b + 2;
   endfunction : near
   task automatic hs(ref logic s, inout int n);
      logic hit;
      hit = 1'b0;
      while (!hit) begin
         @(negedge i_core_clk);
         hit = s;
         sd = o_rdata;
         sr = o_bvalid ? o_bresp : o_rresp;
         @(posedge i_core_clk);
         guard(n);
      end
   endtask : hs
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      logic ta, tw;
      n = 0;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge i_core_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge i_core_clk);
         ta = ta || o_awready;
         tw = tw || o_wready;
         @(posedge i_core_clk);
         i_awvalid <= !ta;
         i_wvalid <= !tw;
         guard(n);
      end
      hs(o_bvalid, n);
      i_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge i_core_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      hs(o_arready, n);
      i_arvalid <= 1'b0;
      hs(o_rvalid, n);
      i_rready <= 1'b0;
   endtask : rd
   task automatic wait_res();
      int n0, n;
      n0 = res_cnt;
      n = 0;
      while (res_cnt == n0) begin
         @(negedge i_core_clk);
         guard(n);
      end
   endtask : wait_res
   task automatic wait_host(input int n0);
      int n;
      n = 0;
      while (pc == n0) begin
         @(negedge i_core_clk);
         guard(n);
      end
   endtask : wait_host
   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask : done
   task automatic results();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      int t0, ta, n, ch;
      logic [23:0] off;
      slow = 1'b0;
      sd = $urandom(32'hFBA5D85D);
      i_conv_data = sd[23:0] | 24'h000001;
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'b0;
      rd(`AMC_OFF_MODE);
      chk("mode", sd, `AMC_MODE_RESET);
      rd(`AMC_OFF_RATE);
      chk("rate", sd, `AMC_RATE_RESET);
      rd(`AMC_OFF_STATUS);
      chk("ready", sd[`AMC_ST_RDY_N], 1'b1);
      rd(12'h100);
      chk("unmapped", sd, 32'h0);
      chk("rresp", sr, 2'h2);
      wr(12'h100, 32'h1);
      chk("bresp", sr, 2'h2);
      done("reset");
      wr(`AMC_OFF_RATE, PER);
      for (int c = 0; c < 2; c++) begin
         wr(`AMC_OFF_MODE, c << `AMC_CHOP_DISABLE_BIT_BIT);
         t0 = cyc;
         wait_res();
         ta = t_res;
         wait_res();
         chk("first", near(ta - t0, (2 - c) * PER), 1'b1);
         chk("period", t_res - ta, PER);
      end
      done("continuous");
      @(negedge i_core_clk);
      chk("offer", o_result_valid, 1'b0);
      n = pc;
      wr(`AMC_OFF_READ_REQ, 32'h1);
      wait_host(n);
      chk("request", got, last_res);
      slow <= 1'b1;
      wr(`AMC_OFF_MODE, 32'h30);
      wait_res();
      wait_host(pc);
      chk("stream", got, last_res);
      done("readout");
      wr(`AMC_OFF_MODE, 32'h1);
      t0 = cyc;
      wait_res();
      chk("single", near(t_res - t0, SETTLE + 2 * PER), 1'b1);
      @(negedge i_core_clk);
      chk("pdown", {o_power_down, o_ready_n}, 2'b10);
      n = res_cnt;
      repeat (40) @(negedge i_core_clk);
      chk("held", {o_ready_n, res_cnt == n}, 2'b01);
      rd(`AMC_OFF_DATA);
      chk("data", sd[23:0], last_res);
      @(negedge i_core_clk);
      chk("cleared", o_ready_n, 1'b1);
      done("single");
      for (int m = 2; m < 4; m++) begin
         wr(`AMC_OFF_MODE, m);
         @(negedge i_core_clk);
         chk("modes", {o_modulator_reset, o_power_down, o_clock_output_pin_en},
            {1'b1, m == 3, m != 3});
      end
      done("idle and power-down");
      wr(`AMC_OFF_IRQ_MASK, 32'h2);
      ch = $urandom_range(5, 0);
      wr(`AMC_OFF_MODE, 32'h4 | (ch << `AMC_CHAN_LSB));
      @(negedge i_core_clk);
      chk("cal start", {o_ready_n, o_input_short, o_cal_channel}, {2'b11, ch[2:0]});
      t0 = cyc;
      n = 0;
      while (o_input_short) begin
         @(negedge i_core_clk);
         guard(n);
      end
      off = conv_s;
      chk("cal time", near(cyc - t0, 2 * PER), 1'b1);
      @(negedge i_core_clk);
      chk("cal end", o_ready_n, 1'b0);
      rd(`AMC_OFF_MODE);
      chk("cal idle", sd[2:0], 3'h2);
      rd(`AMC_OFF_OFFSET0 + 12'(4 * ch));
      chk("offset", sd[23:0], off);
      done("calibration");
      chk("irq", o_irq, 1'b1);
      wr(`AMC_OFF_IRQ_MASK, 32'h0);
      @(negedge i_core_clk);
      chk("irq masked", o_irq, 1'b0);
      wr(`AMC_OFF_IRQ_MASK, 32'h2);
      @(negedge i_core_clk);
      chk("irq unmasked", o_irq, 1'b1);
      rd(`AMC_OFF_STATUS);
      chk("cal flag", sd[`AMC_ST_CAL_DONE], 1'b1);
      @(negedge i_core_clk);
      chk("irq clear", o_irq, 1'b0);
      done("interrupt");
      results();
   end
endmodule : amc_mode_ctrl_test
